/* File: rtl/embi_pkg.sv */
`default_nettype none
package embi_pkg;
  localparam int ADDR_W = 16;
  localparam int DATA_W = 8;
  localparam int NUM_CPU = 3;
  localparam int CLK_PERIOD_NS = 8;
  // Top 6K of the 64K space stays on chip; everything below goes off chip
  localparam logic [15:0] INT_BASE = 16'he800;
  // External firmware area is the lowest 16K, application space the rest
  localparam logic [15:0] FW_LAST = 16'h3fff;
  localparam logic [15:0] APP_BASE = 16'h4000;
  localparam logic [15:0] SRAM_BASE = 16'he800;
  localparam int SRAM_AW = 11;
  localparam logic [10:0] SRAM_LAST_IDX = 11'h7ff;
  localparam logic [15:0] EE_BASE = 16'hf000;
  localparam logic [15:0] EE_LAST = 16'hf1ff;
  localparam int EE_AW = 9;
  localparam logic [8:0] EE_FACTORY_BYTES = 9'h008;
  // Software allocates variable space in pairs of bytes
  localparam int EE_SEGMENT_BYTES = 2; // see RULE16
  localparam logic [1:0] SLOT_FIRST = 2'h0;
  localparam logic [1:0] SLOT_LAST = 2'h2;
  localparam logic [1:0] SLOT_STEP = 2'h1;
  localparam logic [10:0] IDX_STEP = 11'h001;

  typedef struct packed {
    logic vld;
    logic wr;
    logic [15:0] addr;
    logic [7:0] wdata;
  } embi_req_s;

  typedef enum logic [1:0] {
    ST_INIT = 2'b01,
    ST_RUN = 2'b10
  } embi_state_e;
endpackage
`default_nettype wire

/* File: rtl/embi_top.sv */
// Behaviour
// RULE1: Decode 64K space; top 6K internal, everything lower goes to external bus.
// RULE2: 59,392 bytes external; 6,144 internal bytes never become external transfers.
// RULE3: Lowest 16K external holds firmware; remaining 43,008 bytes for applications.
// RULE4: Attached external memory comes in multiples of 256 bytes.
// RULE5: Device drives 16 address lines; 8 data lines driven on writes, sampled reads.
// RULE6: Only enable strobe and read/write select qualify external transfers.
// RULE7: Enable strobe toggles continuously at half the input clock.
// RULE8: Bus works at input clocks of 10MHz and 6.5536MHz.
// RULE9: Three processors share the bus by phase; one owner per slot, no arbitration.
// RULE10: External glue builds memory strobes from enable, address bit 15, read/write. The test glue uses enable, read/write and data enable, not bit 15.
// RULE11: 2048-byte SRAM kept while powered, cleared by the post-reset init sequence.
// RULE12: 512 bytes of EEPROM sit in the internal region.
// RULE13: All EEPROM bytes writable except 8 factory bytes holding ID and maker code.
// RULE14: EEPROM write compares stored value first; skips programming when equal.
// RULE15: Low-voltage detector holds chip in reset, blocking EEPROM writes.
// RULE16: EEPROM variable space allocated in 2-byte segments on this variant.
// RULE17: Instruction cycle is three system clocks, six input clocks; sets slot rotation.
// RULE18: Read/write select low for writes, high for reads; address stable through strobe.
// RULE19: Data lines released on reads, sampled at strobe end; driven during write strobe.
`timescale 1ns/1ps
`default_nettype none
module embi_top #(
  parameter int EE_PROG_NS = 10000000,
  // Arbitrary value; factory ID and maker code
  parameter logic [63:0] FACTORY_ID = 64'h0123_4567_89ab_cdef
) (
  // Clock and reset
  input wire logic REF_CLK,
  input wire logic RST_B,
  input wire logic LOW_VOLTAGE_RESET_HOLD,
  // Processor slots
  input wire embi_pkg::embi_req_s [2:0] CPU_REQ,
  output logic [2:0] CPU_ACK,
  output logic [7:0] CPU_RDATA,
  // Status
  output logic MEM_READY,
  output logic EE_BUSY,
  // External memory bus
  output logic [15:0] EXT_ADDRESS_LINES,
  output logic [7:0] EXT_DATA_LINES_OUT,
  output logic EXT_DATA_LINES_OE,
  input wire logic [7:0] EXT_DATA_LINES_IN,
  output logic EXT_EN_B,
  output logic EXT_RW
);
  localparam int EE_PROG_CYC_I = (EE_PROG_NS + embi_pkg::CLK_PERIOD_NS - 1) / embi_pkg::CLK_PERIOD_NS;
  localparam int EE_PROG_CYC_M = (EE_PROG_CYC_I < 1) ? 1 : EE_PROG_CYC_I;
  localparam int EE_CNT_W = $clog2(EE_PROG_CYC_M + 1);
  localparam logic [EE_CNT_W-1:0] EE_PROG_CYC = EE_CNT_W'(EE_PROG_CYC_M);
  localparam logic [EE_CNT_W-1:0] EE_CNT_ONE = EE_CNT_W'(1);

  function automatic logic is_internal(input logic [15:0] a);
    return a >= embi_pkg::INT_BASE; // see RULE1
  endfunction
  function automatic logic in_sram(input logic [15:0] a);
    return (a >= embi_pkg::SRAM_BASE) && (a < embi_pkg::EE_BASE);
  endfunction
  function automatic logic in_ee(input logic [15:0] a);
    return (a >= embi_pkg::EE_BASE) && (a <= embi_pkg::EE_LAST); // see RULE12
  endfunction

  // Brown-out forces the same state as the reset pin
  logic rst_b_int;
  assign rst_b_int = RST_B & ~LOW_VOLTAGE_RESET_HOLD; // see RULE15

  logic [7:0] sram [0:2047];
  logic [7:0] ee [0:511];

  embi_pkg::embi_state_e state_r, state_nxt;
  logic [10:0] clr_idx_r, clr_idx_nxt;
  logic phase_r, phase_nxt;
  logic [1:0] slot_r, slot_nxt;
  logic cur_vld_r, cur_vld_nxt;
  logic cur_wr_r, cur_wr_nxt;
  logic cur_ext_r, cur_ext_nxt;
  logic [15:0] cur_addr_r, cur_addr_nxt;
  logic [7:0] wdata_r, wdata_nxt;
  logic [EE_CNT_W-1:0] ee_cnt_r, ee_cnt_nxt;
  logic [2:0] ack_nxt;
  logic [7:0] rdata_nxt;
  logic ready_nxt, ee_busy_nxt;
  logic [15:0] addr_out_nxt;
  logic [7:0] dout_nxt;
  logic oe_nxt, en_b_nxt, rw_nxt;
  embi_pkg::embi_req_s req_c;
  logic take_c;
  logic int_acc_c;
  logic sram_we_c;
  logic [10:0] sram_widx_c;
  logic [7:0] sram_wdat_c;
  logic ee_try_c, ee_we_c;
  logic [8:0] ee_off_c;
  logic [7:0] ee_rd_c;
  logic [7:0] int_rdata_c;
  logic [7:0] int_rdata_r;

  always_comb begin
    state_nxt = state_r;
    clr_idx_nxt = clr_idx_r;
    slot_nxt = slot_r;
    cur_vld_nxt = cur_vld_r;
    cur_wr_nxt = cur_wr_r;
    cur_ext_nxt = cur_ext_r;
    cur_addr_nxt = cur_addr_r;
    wdata_nxt = wdata_r;
    rdata_nxt = CPU_RDATA;
    addr_out_nxt = EXT_ADDRESS_LINES;
    dout_nxt = EXT_DATA_LINES_OUT;
    rw_nxt = EXT_RW;
    oe_nxt = EXT_DATA_LINES_OE;
    ack_nxt = 3'h0;
    // Free-running divide by two; frequency half that of the input clock
    phase_nxt = ~phase_r; // see RULE8
    en_b_nxt = phase_r; // see RULE7
    ready_nxt = MEM_READY;
    req_c = '0;
    take_c = 1'b0;
    sram_we_c = 1'b0;
    sram_widx_c = cur_addr_r[embi_pkg::SRAM_AW-1:0];
    sram_wdat_c = wdata_r;
    ee_off_c = cur_addr_r[embi_pkg::EE_AW-1:0];
    ee_rd_c = (ee_off_c < embi_pkg::EE_FACTORY_BYTES) ? FACTORY_ID[{ee_off_c[2:0], 3'h0} +: 8] : ee[ee_off_c];
    ee_try_c = 1'b0;
    ee_we_c = 1'b0;
    ee_cnt_nxt = (ee_cnt_r != '0) ? ee_cnt_r - EE_CNT_ONE : ee_cnt_r;
    int_acc_c = cur_vld_r && !cur_ext_r && !phase_r;
    int_rdata_c = int_rdata_r;

    unique case (state_r)
      embi_pkg::ST_INIT: begin
        // Whole SRAM wiped one byte per clock before any slot is served
        sram_we_c = 1'b1; // see RULE11
        sram_widx_c = clr_idx_r;
        sram_wdat_c = 8'h00;
        clr_idx_nxt = 11'(clr_idx_r + embi_pkg::IDX_STEP);
        if (clr_idx_r == embi_pkg::SRAM_LAST_IDX) begin
          state_nxt = embi_pkg::ST_RUN;
          ready_nxt = 1'b1;
        end
      end
      embi_pkg::ST_RUN: begin
      end
    endcase

    if (phase_r) begin
      // End of strobe: finish the slot's transfer and open the next slot
      if (cur_vld_r) begin
        ack_nxt[slot_r] = 1'b1; // see RULE9
        rdata_nxt = cur_ext_r ? EXT_DATA_LINES_IN : int_rdata_r; // see RULE19
      end
      oe_nxt = 1'b0;
      slot_nxt = (slot_r == embi_pkg::SLOT_LAST) ? embi_pkg::SLOT_FIRST :
                 2'(slot_r + embi_pkg::SLOT_STEP); // see RULE17
      req_c = CPU_REQ[slot_nxt];
      take_c = (state_r == embi_pkg::ST_RUN) && req_c.vld;
      cur_vld_nxt = take_c;
      cur_wr_nxt = req_c.wr;
      cur_ext_nxt = !is_internal(req_c.addr); // see RULE2
      cur_addr_nxt = req_c.addr;
      wdata_nxt = req_c.wdata;
      rw_nxt = 1'b1; // see RULE6
      // Internal hits leave the address and data pins as they were; the select goes high
      // Firmware and application space go out alike
      if (take_c && !is_internal(req_c.addr)) begin // see RULE3
        addr_out_nxt = req_c.addr; // see RULE5
        rw_nxt = !req_c.wr; // see RULE18
        dout_nxt = req_c.wdata;
      end
    end else begin
      oe_nxt = cur_vld_r && cur_ext_r && cur_wr_r; // see RULE19
    end

    if (int_acc_c) begin
      if (in_sram(cur_addr_r)) begin
        int_rdata_c = sram[cur_addr_r[embi_pkg::SRAM_AW-1:0]];
        sram_we_c = cur_wr_r;
      end else if (in_ee(cur_addr_r)) begin
        int_rdata_c = ee_rd_c;
        ee_try_c = cur_wr_r;
      end else begin
        // I/O window holds nothing here
        int_rdata_c = 8'h00;
      end
    end

    // Writes while a byte is still programming are dropped
    if (ee_try_c && (ee_off_c >= embi_pkg::EE_FACTORY_BYTES) && (ee_cnt_r == '0)) begin // see RULE13
      if (ee_rd_c != wdata_r) begin // see RULE14
        ee_we_c = 1'b1;
        ee_cnt_nxt = EE_PROG_CYC;
      end
    end
    ee_busy_nxt = (ee_cnt_nxt != '0);
  end

  always_ff @(posedge REF_CLK or negedge rst_b_int) begin
    if (!rst_b_int) begin
      state_r <= embi_pkg::ST_INIT;
      clr_idx_r <= 11'h000;
      phase_r <= 1'b0;
      slot_r <= embi_pkg::SLOT_LAST;
      cur_vld_r <= 1'b0;
      cur_wr_r <= 1'b0;
      cur_ext_r <= 1'b0;
      cur_addr_r <= 16'h0000;
      wdata_r <= 8'h00;
      ee_cnt_r <= '0;
      int_rdata_r <= 8'h00;
      CPU_ACK <= 3'h0;
      CPU_RDATA <= 8'h00;
      MEM_READY <= 1'b0;
      EE_BUSY <= 1'b0;
      EXT_ADDRESS_LINES <= 16'h0000;
      EXT_DATA_LINES_OUT <= 8'h00;
      EXT_DATA_LINES_OE <= 1'b0;
      EXT_EN_B <= 1'b1;
      EXT_RW <= 1'b1;
    end else begin
      state_r <= state_nxt;
      clr_idx_r <= clr_idx_nxt;
      phase_r <= phase_nxt;
      slot_r <= slot_nxt;
      cur_vld_r <= cur_vld_nxt;
      cur_wr_r <= cur_wr_nxt;
      cur_ext_r <= cur_ext_nxt;
      cur_addr_r <= cur_addr_nxt;
      wdata_r <= wdata_nxt;
      ee_cnt_r <= ee_cnt_nxt;
      int_rdata_r <= int_rdata_c;
      CPU_ACK <= ack_nxt;
      CPU_RDATA <= rdata_nxt;
      MEM_READY <= ready_nxt;
      EE_BUSY <= ee_busy_nxt;
      EXT_ADDRESS_LINES <= addr_out_nxt;
      EXT_DATA_LINES_OUT <= dout_nxt;
      EXT_DATA_LINES_OE <= oe_nxt;
      EXT_EN_B <= en_b_nxt;
      EXT_RW <= rw_nxt;
    end
  end

  // Arrays carry no reset: SRAM contents survive until the init wipe, EEPROM contents are never wiped
  always_ff @(posedge REF_CLK) begin
    if (sram_we_c) begin
      sram[sram_widx_c] <= sram_wdat_c;
    end
    if (ee_we_c) begin
      ee[ee_off_c] <= wdata_r;
    end
  end

  default clocking @(posedge REF_CLK); endclocking
  default disable iff (!rst_b_int);

  sequence ext_rd_take_s;
    take_c && !is_internal(req_c.addr) && !req_c.wr;
  endsequence
  sequence ext_wr_take_s;
    take_c && !is_internal(req_c.addr) && req_c.wr;
  endsequence
  sequence int_take_s;
    take_c && is_internal(req_c.addr);
  endsequence

  strobe_toggle_a: assert property (EXT_EN_B |=> !EXT_EN_B ##1 EXT_EN_B) // see RULE7
    else $error("enable strobe stopped toggling");
  addr_hold_a: assert property (!EXT_EN_B |-> $stable(EXT_ADDRESS_LINES) && $stable(EXT_RW)) // see RULE18
    else $error("address or select moved during strobe");
  write_drive_a: assert property (EXT_DATA_LINES_OE |-> !EXT_EN_B && !EXT_RW) // see RULE19
    else $error("data driven outside a write strobe");
  ext_read_a: assert property (ext_rd_take_s |=> (EXT_RW && EXT_ADDRESS_LINES == $past(cur_addr_nxt))
    ##1 (!EXT_EN_B && !EXT_DATA_LINES_OE)) // see RULE18
    else $error("external read not presented");
  ext_write_a: assert property (ext_wr_take_s |=> !EXT_RW ##1 (EXT_DATA_LINES_OE && !EXT_EN_B)) // see RULE5
    else $error("external write not driven");
  int_quiet_a: assert property (int_take_s |=> (EXT_RW && $stable(EXT_ADDRESS_LINES) && !EXT_DATA_LINES_OE) [*2]) // see RULE2
    else $error("internal access leaked to bus");
  ack_timing_a: assert property (take_c |-> ##3 (CPU_ACK != 3'h0) && $onehot(CPU_ACK)) // see RULE9
    else $error("slot answer late or shared");
  slot_cycle_a: assert property ((phase_r && slot_r == 2'h0) |-> ##2 (slot_r == 2'h1) ##4 (phase_r && slot_r == 2'h0)) // see RULE17
    else $error("slot rotation not six clocks");
  ee_skip_a: assert property ((ee_try_c && ee_rd_c == wdata_r) |-> !ee_we_c ##1 !$rose(EE_BUSY)) // see RULE14
    else $error("equal byte was programmed");
  ee_protect_a: assert property (ee_we_c |-> ee_off_c >= embi_pkg::EE_FACTORY_BYTES ##1 EE_BUSY) // see RULE13
    else $error("factory byte written or busy missing");
  init_ready_a: assert property (!MEM_READY |-> CPU_ACK == 3'h0 && state_r == embi_pkg::ST_INIT) // see RULE11
    else $error("access served before SRAM clear");
endmodule
`default_nettype wire

/* File: tb/embi_ext_mem.sv */
`timescale 1ns/1ps
`default_nettype none
module embi_ext_mem #(
  parameter int POP_BYTES = 59392
) (
  // Bus from the device
  input wire logic clk,
  input wire logic [15:0] addr,
  input wire logic [7:0] dout,
  input wire logic oe,
  input wire logic en_b,
  input wire logic rw,
  // Data back to the device
  output logic [7:0] din
);
  logic [7:0] mem [0:65535];
  logic [7:0] last_r = 8'h00;
  // Glue strobes built from enable and select; the write strobe is also gated by the data enable
  wire logic rd_en = !en_b && rw;
  wire logic wr_en = !en_b && !rw && oe;
  // Only whole pages are fitted
  wire logic hit = int'(addr) < (POP_BYTES / 256) * 256;
  // Released bus shows a changing pattern, so a stale byte never reads as good
  assign din = (rd_en && hit) ? mem[addr] : ~last_r;
  always @(posedge clk) begin
    last_r <= din;
    if (wr_en && hit) begin
      mem[addr] <= dout;
    end
  end
endmodule
`default_nettype wire

/* File: tb/test_embi_top.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin fails++; $display("BAD %0t got %h exp %h", $time, a, e); end end
module test_embi_top;
  logic ref_clk = 1'b0;
  logic rst_b = 1'b0;
  logic low_volt = 1'b0;
  embi_pkg::embi_req_s [2:0] cpu_req = '0;
  logic [2:0] cpu_ack;
  logic [7:0] cpu_rdata, ext_dout, ext_din, r0, r1, r2;
  logic mem_ready, ee_busy, ext_oe, ext_en_b, ext_rw, bus_rw, bus_oe, g0, g1, g2;
  logic [15:0] ext_addr, bus_a;
  int fails = 0;
  int total_checks = 0;

  // Arbitrary factory value
  embi_top #(.EE_PROG_NS(200), .FACTORY_ID(64'h1122_3344_5566_7788)) embi_top_i (
    .REF_CLK(ref_clk), .RST_B(rst_b), .LOW_VOLTAGE_RESET_HOLD(low_volt),
    .CPU_REQ(cpu_req), .CPU_ACK(cpu_ack), .CPU_RDATA(cpu_rdata), .MEM_READY(mem_ready),
    .EE_BUSY(ee_busy), .EXT_ADDRESS_LINES(ext_addr), .EXT_DATA_LINES_OUT(ext_dout),
    .EXT_DATA_LINES_OE(ext_oe), .EXT_DATA_LINES_IN(ext_din), .EXT_EN_B(ext_en_b), .EXT_RW(ext_rw));
  embi_ext_mem embi_ext_mem_i (.clk(ref_clk), .addr(ext_addr), .dout(ext_dout), .oe(ext_oe),
    .en_b(ext_en_b), .rw(ext_rw), .din(ext_din));

  initial begin
    forever #4 ref_clk = ~ref_clk;
  end

  always @(negedge ref_clk) begin
    if (rst_b === 1'b1 && cpu_ack !== 3'h0) begin
      `CHK(cpu_ack & (cpu_ack - 3'h1), 3'h0)
    end
  end

  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic xfer(input int k, input logic wr, input logic [15:0] a, input logic [7:0] d,
                      output logic [7:0] rd, output logic got);
    int n;
    got = 1'b0;
    bus_rw = 1'b1;
    bus_oe = 1'b0;
    @(posedge ref_clk);
    cpu_req[k] <= '{vld: 1'b1, wr: wr, addr: a, wdata: d};
    for (n = 0; n < 40 && !got; n++) begin
      @(posedge ref_clk);
      #1;
      if (ext_en_b === 1'b0) begin
        bus_a = ext_addr;
        bus_rw = bus_rw & ext_rw;
        bus_oe = bus_oe | ext_oe;
      end
      got = (cpu_ack[k] === 1'b1);
    end
    rd = cpu_rdata;
    @(posedge ref_clk);
    cpu_req[k].vld <= 1'b0;
    if (!got) begin
      fails++;
      $display("BAD %0t no answer", $time);
      close_out();
    end
  endtask

  task automatic wait_ready();
    int n;
    for (n = 0; n < 3000 && mem_ready !== 1'b1; n++) begin
      @(posedge ref_clk);
      #1;
    end
    `CHK(mem_ready, 1'b1)
    if (mem_ready !== 1'b1) close_out();
  endtask

  task automatic t_ext();
    xfer(1, 1'b1, 16'h4000, 8'h5a, r0, g0);
    `CHK({bus_a, bus_rw, bus_oe}, {16'h4000, 2'b01})
    `CHK(embi_ext_mem_i.mem[16'h4000], 8'h5a)
    xfer(2, 1'b1, 16'he7ff, 8'hc3, r0, g0);
    xfer(2, 1'b0, 16'he7ff, 8'h00, r0, g0);
    `CHK({r0, bus_a, bus_rw, bus_oe}, {8'hc3, 16'he7ff, 2'b10})
    $display("external transfers done");
  endtask

  task automatic t_sram();
    xfer(0, 1'b0, 16'he900, 8'h00, r0, g0);
    `CHK(r0, 8'h00)
    xfer(0, 1'b1, 16'he800, 8'h33, r0, g0);
    `CHK({bus_rw, bus_oe}, 2'b10)
    xfer(1, 1'b0, 16'he800, 8'h00, r0, g0);
    `CHK(r0, 8'h33)
    xfer(1, 1'b1, 16'hf800, 8'h77, r0, g0);
    xfer(1, 1'b0, 16'hf800, 8'h00, r0, g0);
    `CHK(r0, 8'h00)
    $display("sram done");
  endtask

  task automatic t_ee();
    int n;
    xfer(0, 1'b0, 16'hf000, 8'h00, r0, g0);
    xfer(0, 1'b0, 16'hf007, 8'h00, r1, g0);
    `CHK({r0, r1}, 16'h8811)
    xfer(0, 1'b1, 16'hf000, 8'h00, r0, g0);
    #1;
    `CHK(ee_busy, 1'b0)
    xfer(0, 1'b0, 16'hf000, 8'h00, r0, g0);
    `CHK(r0, 8'h88)
    xfer(2, 1'b1, 16'hf010, 8'ha5, r0, g0);
    #1;
    `CHK(ee_busy, 1'b1)
    for (n = 0; n < 100 && ee_busy === 1'b1; n++) begin
      @(posedge ref_clk);
      #1;
    end
    `CHK(ee_busy, 1'b0)
    if (ee_busy !== 1'b0) close_out();
    xfer(2, 1'b0, 16'hf010, 8'h00, r0, g0);
    `CHK(r0, 8'ha5)
    xfer(2, 1'b1, 16'hf010, 8'ha5, r0, g0);
    #1;
    `CHK(ee_busy, 1'b0)
    $display("eeprom done");
  endtask

  task automatic t_three();
    fork
      xfer(0, 1'b1, 16'h0100, 8'h11, r0, g0);
      xfer(1, 1'b1, 16'h3fff, 8'h22, r1, g1);
      xfer(2, 1'b1, 16'h8000, 8'h44, r2, g2);
    join
    `CHK(embi_ext_mem_i.mem[16'h3fff], 8'h22)
    fork
      xfer(0, 1'b0, 16'h8000, 8'h00, r0, g0);
      xfer(1, 1'b0, 16'h0100, 8'h00, r1, g1);
      xfer(2, 1'b0, 16'h3fff, 8'h00, r2, g2);
    join
    `CHK({r0, r1, r2}, 24'h441122)
    $display("shared bus done");
  endtask

  task automatic t_lvr();
    @(posedge ref_clk);
    low_volt <= 1'b1;
    @(posedge ref_clk);
    #1;
    `CHK({ext_en_b, ext_oe, mem_ready}, 3'b100)
    @(posedge ref_clk);
    low_volt <= 1'b0;
    wait_ready();
    xfer(0, 1'b0, 16'he800, 8'h00, r0, g0);
    `CHK(r0, 8'h00)
    $display("brown-out done");
  endtask

  initial begin
    repeat (5) @(posedge ref_clk);
    #1;
    `CHK({ext_en_b, ext_rw, ext_oe, mem_ready, cpu_ack}, 7'h60)
    @(posedge ref_clk);
    rst_b <= 1'b1;
    wait_ready();
    g0 = ext_en_b;
    repeat (6) begin
      @(posedge ref_clk);
      #1;
      `CHK(ext_en_b, ~g0)
      g0 = ext_en_b;
    end
    t_ext();
    t_sram();
    t_ee();
    t_three();
    t_lvr();
    close_out();
  end
endmodule
`default_nettype wire
